/* hw/sfc_pkg.sv */
package sfc_pkg;

    // ----------------------------------------------------------------
    // Register selection codes carried in the low nibble of each word
    // ----------------------------------------------------------------
    localparam logic [3:0] SEL_R0  = 4'h0;  // Frequency apply word.
    localparam logic [3:0] SEL_R4  = 4'h4;  // Reference divider word.
    localparam logic [3:0] SEL_R10 = 4'hA;  // Temperature converter control.
    localparam logic [3:0] SEL_R11 = 4'hB;  // Fixed reserved word.
    localparam logic [3:0] SEL_R12 = 4'hC;  // Resync timeout control.
    localparam int         NUM_REGS = 13;   // Words 0 to 12 are stored.
    localparam int         SEL_LSB  = 0;    // Select field position.
    localparam int         SEL_W    = 4;    // Select field width.
    localparam logic [31:0] WORD_RESET = 32'h0000_0000; // Stored word after reset.

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SETTLE_LSB = 4;   // Lock-settle count, 5 bits.
    localparam int SETTLE_W   = 5;
    localparam int BAND_LSB   = 14;  // Band-settle timeout, 10 bits.
    localparam int BAND_W     = 10;
    localparam int CDIV_LSB   = 6;   // Converter clock divisor, 8 bits.
    localparam int CDIV_W     = 8;
    localparam int CONV_WR_BIT  = 5; // Convert on every write.
    localparam int CONV_PWR_BIT = 4; // Converter power.
    localparam int RSY_LSB    = 16;  // Resync timeout count, 16 bits.
    localparam int RSY_W      = 16;
    localparam int INT_LSB    = 4;   // Whole divide value.
    localparam int INT_W      = 16;
    localparam int PRIMARY_NUMERATOR_LSB  = 4;   // Primary numerator.
    localparam int PRIMARY_NUMERATOR_W    = 24;  // Matches the fixed 24-bit denominator.
    localparam int AUX_NUMERATOR_LSB  = 18;  // Auxiliary numerator.
    localparam int AUX_NUMERATOR_W    = 14;
    localparam int AUX_DENOMINATOR_LSB   = 4;   // Auxiliary denominator.
    localparam int AUX_DENOMINATOR_W     = 14;
    localparam int RDIV_LSB   = 15;  // Reference division factor.
    localparam int RDIV_W     = 10;
    localparam int RHALF_BIT  = 25;  // Reference divide-by-2.
    localparam int RDBL_BIT   = 26;  // Reference doubler.
    localparam logic [RDIV_W-1:0] RDIV_RESET = 10'h001; // Factor before programming.

endpackage : sfc_pkg

/* hw/sfc_tick_div.sv */
`timescale 1ns/100ps
module sfc_tick_div
#(
    parameter int W = 8                    // Width of the divisor.
)
(
    input  wire logic         mclk,       // System clock.
    input  wire logic         sys_rst,    // Synchronous reset, active high.
    input  wire logic         clear,      // Restart the count.
    input  wire logic         in_tick,    // Input event, one cycle.
    input  wire logic [W-1:0] divisor,    // Events per output, zero acts as one.
    output logic              out_tick    // Output event, one cycle.
);

    // ------------------------------------------------------------
    // Event divider
    // ------------------------------------------------------------
    logic [W-1:0] cnt;         // Events seen since the last output.
    logic [W-1:0] next_cnt;    // Next event count.
    logic         next_out;    // Next output pulse.
    logic [W-1:0] eff;         // Divisor with zero mapped to one.

    // Count input events and emit one pulse per divisor of them.
    always_comb
    begin
        eff      = (divisor == '0) ? W'(1) : divisor;
        next_cnt = cnt;
        next_out = 1'b0;
        if (clear)
        begin
            next_cnt = '0;
        end
        else if (in_tick)
        begin
            if (cnt + W'(1) >= eff)
            begin
                next_cnt = '0;
                next_out = 1'b1;
            end
            else
            begin
                next_cnt = cnt + W'(1);
            end
        end
    end

    // Register the count and the pulse.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cnt      <= '0;
            out_tick <= 1'b0;
        end
        else
        begin
            cnt      <= next_cnt;
            out_tick <= next_out;
        end
    end

    // An output pulse always follows an input event.
    AST_DIV_CAUSE: assert property (@(posedge mclk) disable iff (sys_rst)
        out_tick |-> $past(in_tick))
        else $error("Divider output without an input event.");

endmodule : sfc_tick_div

/* hw/sfc_top.sv */
// Behaviour
// - Select code 1010 loads converter control word.
// - Converter clock is compare clock over divisor.
// - Divisor is eight bits at 13:6.
// - Reference factor is one until programmed.
// - Convert bit starts conversion each write.
// - Power bit enables the temperature converter.
// - Select code 1100 loads resync word.
// - Resync timeout is 16 bits, zero invalid.
// - Only a zero write applies new frequency.
// - Feedback is whole plus fractional parts.
// - Compare clock from reference, doubler, dividers.
// - Low four bits select the target register.
// - Band-settle timeout sits at bits 23:14.
`timescale 1ns/100ps
module sfc_top
    import sfc_pkg::*;
(
    input  wire logic                          mclk,          // System clock, 125 MHz.
    input  wire logic                          sys_rst,       // Synchronous reset.
    input  wire logic                          ser_clk,       // Serial clock pin.
    input  wire logic                          ser_data,      // Serial data pin.
    input  wire logic                          load_strobe,   // Load strobe pin.
    input  wire logic                          ref_in,        // Reference input pin.
    output logic                               compare_tick,  // Compare clock event.
    output logic                               converter_tick, // Converter clock event.
    output logic                               converter_power, // Converter powered.
    output logic                               convert_start, // Conversion start pulse.
    output logic                               freq_update,   // New frequency applied.
    output logic                               resync_pulse,  // Phase resync event.
    output logic [sfc_pkg::INT_W-1:0]          n_int,         // Whole divide value.
    output logic [sfc_pkg::PRIMARY_NUMERATOR_W+sfc_pkg::AUX_DENOMINATOR_W:0] n_frac_num, // Fraction over 2^24*aux.
    output logic [sfc_pkg::AUX_DENOMINATOR_W-1:0]         aux_denominator, // Auxiliary denominator.
    output logic [sfc_pkg::SETTLE_W-1:0]       lock_settle_count, // Settle multiplier.
    output logic [sfc_pkg::BAND_W-1:0]         band_settle_timeout // Settle timeout.
);

    // ------------------------------------------------------------
    // Pin synchronisers and serial shifter
    // ------------------------------------------------------------
    // Bit order in the sync vectors: 0 clock, 1 data, 2 strobe, 3 reference.
    logic [3:0]  sync_a;       // First stage, read only by the second.
    logic [3:0]  sync_b;       // Second stage, safe to use.
    logic [3:0]  sync_c;       // Previous second-stage value for edges.
    logic [31:0] shift;        // Word being shifted in.
    logic [31:0] next_shift;   // Next shifter value.
    logic        sclk_rise;    // Serial clock rising edge.
    logic        le_rise;      // Load strobe rising edge.
    logic        ref_rise;     // Reference rising edge.
    logic        ref_fall;     // Reference falling edge.
    logic [SEL_W-1:0] sel;     // Target of the word in the shifter.

    // Pins change on their own time, so edges are taken after two flops.
    always_comb
    begin
        sclk_rise  = sync_b[0] & ~sync_c[0];
        le_rise    = sync_b[2] & ~sync_c[2];
        ref_rise   = sync_b[3] & ~sync_c[3];
        ref_fall   = ~sync_b[3] & sync_c[3];
        sel        = shift[SEL_LSB +: SEL_W];
        next_shift = shift;
        if (sclk_rise)
        begin
            next_shift = {shift[30:0], sync_b[1]};
        end
    end

    // Register the synchronisers and the shifter.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            sync_c <= 4'h0;
            shift  <= 32'h0000_0000;
        end
        else
        begin
            sync_a <= {ref_in, load_strobe, ser_data, ser_clk};
            sync_b <= sync_a;
            sync_c <= sync_b;
            shift  <= next_shift;
        end
    end

    // ------------------------------------------------------------
    // Register file and frequency apply
    // ------------------------------------------------------------
    logic [31:0] regs [NUM_REGS];      // Stored words by select code.
    logic [31:0] next_regs [NUM_REGS]; // Next stored words.
    logic        r_prog;               // Reference divider has been written.
    logic        next_r_prog;          // Next programmed flag.
    logic        next_conv_start;      // Next conversion start.
    logic        next_freq_update;     // Next apply pulse.
    logic [INT_W-1:0]          next_int;   // Next whole value.
    logic [PRIMARY_NUMERATOR_W+AUX_DENOMINATOR_W:0]   next_num;   // Next fractional numerator.
    logic [AUX_DENOMINATOR_W-1:0]         next_aux_denominator;  // Next auxiliary denominator.
    logic [PRIMARY_NUMERATOR_W+AUX_DENOMINATOR_W-1:0] prod;       // Primary numerator times aux.

    // A word lands on the strobe edge; the frequency only moves on word 0,
    // so a half-written update never reaches the loop.
    always_comb
    begin
        next_regs        = regs;
        next_r_prog      = r_prog;
        next_conv_start  = 1'b0;
        next_freq_update = 1'b0;
        next_int         = n_int;
        next_num         = n_frac_num;
        next_aux_denominator        = aux_denominator;
        prod = (PRIMARY_NUMERATOR_W+AUX_DENOMINATOR_W)'(regs[1][PRIMARY_NUMERATOR_LSB +: PRIMARY_NUMERATOR_W])
             * (PRIMARY_NUMERATOR_W+AUX_DENOMINATOR_W)'(regs[2][AUX_DENOMINATOR_LSB +: AUX_DENOMINATOR_W]);
        if (le_rise && (int'(sel) < NUM_REGS))
        begin
            next_regs[sel] = shift;
            if (sel == SEL_R4)
            begin
                next_r_prog = 1'b1;
            end
            if ((sel == SEL_R10) && shift[CONV_WR_BIT])
            begin
                next_conv_start = 1'b1;
            end
            if (sel == SEL_R0)
            begin
                next_freq_update = 1'b1;
                next_int  = shift[INT_LSB +: INT_W];
                // Value is int + num / (2^24 * aux denominator).
                next_num  = (PRIMARY_NUMERATOR_W+AUX_DENOMINATOR_W+1)'(prod)
                          + (PRIMARY_NUMERATOR_W+AUX_DENOMINATOR_W+1)'(regs[2][AUX_NUMERATOR_LSB +: AUX_NUMERATOR_W]);
                next_aux_denominator = regs[2][AUX_DENOMINATOR_LSB +: AUX_DENOMINATOR_W];
            end
        end
    end

    // Register the stored words and the applied setting.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                regs[i] <= WORD_RESET;
            end
            r_prog          <= 1'b0;
            convert_start   <= 1'b0;
            freq_update     <= 1'b0;
            n_int           <= '0;
            n_frac_num      <= '0;
            aux_denominator <= '0;
        end
        else
        begin
            regs            <= next_regs;
            r_prog          <= next_r_prog;
            convert_start   <= next_conv_start;
            freq_update     <= next_freq_update;
            n_int           <= next_int;
            n_frac_num      <= next_num;
            aux_denominator <= next_aux_denominator;
        end
    end

    // Field views of the stored words.
    assign converter_power     = regs[SEL_R10][CONV_PWR_BIT];
    assign lock_settle_count   = regs[9][SETTLE_LSB +: SETTLE_W];
    assign band_settle_timeout = regs[9][BAND_LSB +: BAND_W];

    // ------------------------------------------------------------
    // Compare clock, converter clock and resync timeout
    // ------------------------------------------------------------
    logic [RDIV_W:0] ref_div;    // Reference factor times divide-by-2.
    logic [RDIV_W-1:0] r_fact;   // Reference factor in use.
    logic            ref_ev;     // Reference event, both edges when doubled.
    logic [RSY_W-1:0] rsy_cnt;   // Compare ticks left before resync.
    logic [RSY_W-1:0] next_rsy_cnt; // Next resync count.
    logic            next_resync;   // Next resync pulse.

    // The factor is one until word 4 arrives; doubling counts both edges.
    always_comb
    begin
        r_fact  = r_prog ? regs[SEL_R4][RDIV_LSB +: RDIV_W] : RDIV_RESET;
        ref_div = {1'b0, r_fact} << regs[SEL_R4][RHALF_BIT];
        ref_ev  = ref_rise | (regs[SEL_R4][RDBL_BIT] & ref_fall);
    end

    sfc_tick_div #(.W(RDIV_W+1)) u_cmp_div (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clear    (1'b0),
        .in_tick  (ref_ev),
        .divisor  (ref_div),
        .out_tick (compare_tick)
    );

    // Restarting on each converter word with the convert bit set keeps the phase tied to the write.
    sfc_tick_div #(.W(CDIV_W)) u_conv_div (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clear    (convert_start),
        .in_tick  (compare_tick),
        .divisor  (regs[SEL_R10][CDIV_LSB +: CDIV_W]),
        .out_tick (converter_tick)
    );

    // A zero timeout is not allowed, so it simply never arms the counter.
    always_comb
    begin
        next_rsy_cnt = rsy_cnt;
        next_resync  = 1'b0;
        if (freq_update)
        begin
            next_rsy_cnt = regs[SEL_R12][RSY_LSB +: RSY_W];
        end
        else if (compare_tick && (rsy_cnt != '0))
        begin
            next_rsy_cnt = rsy_cnt - RSY_W'(1);
            next_resync  = (rsy_cnt == RSY_W'(1));
        end
    end

    // Register the resync timer.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rsy_cnt      <= '0;
            resync_pulse <= 1'b0;
        end
        else
        begin
            rsy_cnt      <= next_rsy_cnt;
            resync_pulse <= next_resync;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_REG10_ROUTE: assert property (@(posedge mclk) disable iff (sys_rst)
        (le_rise && sel == SEL_R10) |=> (regs[SEL_R10] == $past(shift)))
        else $error("Converter word not stored.");
    AST_REG12_ROUTE: assert property (@(posedge mclk) disable iff (sys_rst)
        (le_rise && sel == SEL_R12) |=> (regs[SEL_R12] == $past(shift)))
        else $error("Resync word not stored.");
    AST_CONV_START: assert property (@(posedge mclk) disable iff (sys_rst)
        (le_rise && sel == SEL_R10 && shift[CONV_WR_BIT]) |=> convert_start)
        else $error("Conversion not started.");
    AST_FREQ_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        (n_int != $past(n_int)) |-> $past(le_rise && sel == SEL_R0))
        else $error("Frequency moved without word 0.");
    AST_SHIFT_MSB: assert property (@(posedge mclk) disable iff (sys_rst)
        sclk_rise |=> (shift[31:1] == $past(shift[30:0])))
        else $error("Shift order wrong.");
    AST_R_DEFAULT: assert property (@(posedge mclk) disable iff (sys_rst)
        !r_prog |-> (r_fact == RDIV_RESET))
        else $error("Reference factor not one before programming.");
    AST_RESYNC: assert property (@(posedge mclk) disable iff (sys_rst)
        resync_pulse |-> ($past(compare_tick) && $past(rsy_cnt) == 16'h0001))
        else $error("Resync fired early.");
    AST_POWER: assert property (@(posedge mclk) disable iff (sys_rst)
        (le_rise && sel == SEL_R10) |=> (converter_power == $past(shift[CONV_PWR_BIT])))
        else $error("Converter power not following word.");

endmodule : sfc_top

/* tb/sfc_host_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host controller model driving the three-wire serial link
// ----------------------------------------------------------------
module sfc_host_model
(
    input  wire logic mclk,        // System clock, pins change after its rising edge.
    output logic      ser_clk,     // Serial clock, still between words.
    output logic      ser_data,    // Serial data, most significant bit first.
    output logic      load_strobe  // Load strobe, rising edge loads the word.
);
    // Each pin level is held four cycles, one more than the input sync needs.
    localparam int HOLD = 4;

    // Idle levels at time zero: clock and strobe low.
    initial
    begin
        ser_clk     = 1'b0;
        ser_data    = 1'b1;
        load_strobe = 1'b0;
    end

    // Shifts one word and loads it; a slow host only widens HOLD.
    task automatic send_word(input logic [31:0] word);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge mclk);
            ser_data <= word[i];
            repeat (HOLD) @(posedge mclk);
            ser_clk <= 1'b1;
            repeat (HOLD) @(posedge mclk);
            ser_clk <= 1'b0;
        end
        repeat (HOLD) @(posedge mclk);
        load_strobe <= 1'b1;
        // The data line no longer means anything, so it shows the opposite level.
        ser_data    <= ~word[0];
        repeat (HOLD) @(posedge mclk);
        load_strobe <= 1'b0;
        repeat (HOLD) @(posedge mclk);
    endtask : send_word
endmodule : sfc_host_model

/* tb/sfc_top_tb_top.sv */
`timescale 1ns/100ps
module sfc_top_tb_top;
    import sfc_pkg::*;

    // ----------------------------------------------------------------
    // Signals and counters
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] word;   // Word sent by the host.
        logic        pw;     // Expected converter power level.
        logic [1:0]  cs;     // Expected conversion start pulses.
        logic [1:0]  fu;     // Expected frequency update pulses.
    } sfc_row_s;

    logic                      mclk;            // System clock.
    logic                      sys_rst;         // Synchronous reset.
    logic                      ser_clk;         // Serial clock from the host.
    logic                      ser_data;        // Serial data from the host.
    logic                      load_strobe;     // Load strobe from the host.
    logic                      ref_in;          // Reference input.
    logic [2:0]                ref_cnt;         // Reference generator count.
    logic                      compare_tick;    // Compare clock event.
    logic                      converter_tick;  // Converter clock event.
    logic                      converter_power; // Converter powered.
    logic                      convert_start;   // Conversion start pulse.
    logic                      freq_update;     // Frequency applied pulse.
    logic                      resync_pulse;    // Resync event.
    logic [INT_W-1:0]          n_int;           // Whole divide value.
    logic [PRIMARY_NUMERATOR_W+AUX_DENOMINATOR_W:0]   n_frac_num;      // Fraction numerator.
    logic [AUX_DENOMINATOR_W-1:0]         aux_denominator; // Auxiliary denominator.
    logic [SETTLE_W-1:0]       lock_settle_count;   // Settle multiplier.
    logic [BAND_W-1:0]         band_settle_timeout; // Settle timeout.
    int                        errors;          // Mismatches seen.
    int                        compares;        // Comparisons made.
    int                        ncs;             // Conversion starts seen.
    int                        nfu;             // Frequency updates seen.
    int                        nrs;             // Resync pulses seen.
    int                        c0;              // Snapshot of ncs.
    int                        f0;              // Snapshot of nfu.
    int                        per;             // Measured tick period.
    sfc_row_s                  rows [6];        // Ordinary cases.

    // Converter period in system cycles: divisor 39 over a compare tick every 8.
    localparam int CONV_PER = 39 * 8;

    // ----------------------------------------------------------------
    // Clock, reference and instances
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Reference of eight system cycles, slow enough for the input sync.
    always @(posedge mclk)
    begin
        ref_cnt <= ref_cnt + 3'h1;
        ref_in  <= ref_cnt[2];
    end

    // Pulse counters, so no pulse slips between two samples.
    always @(posedge mclk)
    begin
        ncs <= ncs + int'(convert_start === 1'b1);
        nfu <= nfu + int'(freq_update === 1'b1);
        nrs <= nrs + int'(resync_pulse === 1'b1);
    end

    sfc_host_model host (.mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data),
                         .load_strobe(load_strobe));

    sfc_top dut (.mclk(mclk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data(ser_data),
                 .load_strobe(load_strobe), .ref_in(ref_in), .compare_tick(compare_tick),
                 .converter_tick(converter_tick), .converter_power(converter_power),
                 .convert_start(convert_start), .freq_update(freq_update),
                 .resync_pulse(resync_pulse), .n_int(n_int), .n_frac_num(n_frac_num),
                 .aux_denominator(aux_denominator), .lock_settle_count(lock_settle_count),
                 .band_settle_timeout(band_settle_timeout));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Counts system cycles between two ticks, sampled on the falling edge.
    task automatic period(input bit conv, output int n);
        int k;
        k = 0;
        do @(negedge mclk); while ((conv ? converter_tick : compare_tick) !== 1'b1);
        do
        begin
            @(negedge mclk);
            k++;
        end
        while ((conv ? converter_tick : compare_tick) !== 1'b1 && k < 2000);
        n = k;
    endtask : period

    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        ref_in  = 1'b0;
        ref_cnt = 3'h0;
        errors   = 0;
        compares = 0;
        ncs      = 0;
        nfu      = 0;
        nrs      = 0;
        // Converter word: reserved 23:22 set, divisor 39 for a 15.625 MHz
        // compare clock, convert and power on.
        rows[0] = '{32'h00C009FA, 1'b1, 2'h1, 2'h0};
        rows[1] = '{32'h0081200B, 1'b1, 2'h0, 2'h0};
        rows[2] = '{32'h0003050C, 1'b1, 2'h0, 2'h0};
        rows[3] = '{32'hFFFFFFFD, 1'b1, 2'h0, 2'h0};
        rows[4] = '{32'h00C009CA, 1'b0, 2'h0, 2'h0};
        rows[5] = '{32'h00000640, 1'b0, 2'h0, 2'h1};
        repeat (10) @(negedge mclk);
        check(64'({freq_update, converter_power, n_int}), 64'h0);
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 6; i++)
        begin
            c0 = ncs;
            f0 = nfu;
            // The host lets the converter settle before any word 0.
            if (rows[i].word[SEL_LSB +: SEL_W] == SEL_R0)
            begin
                repeat (17 * CONV_PER) @(posedge mclk);
            end
            host.send_word(rows[i].word);
            check(64'(converter_power), 64'(rows[i].pw));
            check(64'(ncs - c0), 64'(rows[i].cs));
            check(64'(nfu - f0), 64'(rows[i].fu));
        end
        check(64'(n_int), 64'd100);
        repeat (60) @(posedge mclk);
        check(64'(nrs), 64'd1);
        // Divisor 39 is stored even with power off; reference factor still one.
        period(1'b0, per);
        check(64'(per), 64'd8);
        period(1'b1, per);
        check(64'(per), 64'(CONV_PER));
        // Converter word first, then auxiliary denominator 3 with numerator 1,
        // then primary numerator 5.
        host.send_word(32'h00C009FA);
        host.send_word(32'h00040032);
        host.send_word(32'h00000051);
        check(64'({n_int, n_frac_num}), 64'({16'd100, 39'd0}));
        repeat (17 * CONV_PER) @(posedge mclk);
        host.send_word(32'h00000440);
        check(64'(n_int), 64'd68);
        check(64'(n_frac_num), 64'd16);
        check(64'(aux_denominator), 64'd3);
        // Reference factor two doubles the compare period.
        host.send_word(32'h00010004);
        period(1'b0, per);
        check(64'(per), 64'd16);
        check(64'(nrs), 64'd2);
        // Settle count 5 times timeout 100 covers 20 us at either compare rate.
        host.send_word(32'h00193E59);
        check(64'(lock_settle_count), 64'd5);
        check(64'(band_settle_timeout), 64'd100);
        // Doubler with factor two, then divide-by-2 with factor one.
        host.send_word(32'h04010004);
        period(1'b0, per);
        check(64'(per), 64'd8);
        host.send_word(32'h02008004);
        period(1'b0, per);
        check(64'(per), 64'd16);
        // Desired factor one for the final pass.
        host.send_word(32'h00008004);
        period(1'b0, per);
        check(64'(per), 64'd8);
        // A second reset in mid-run clears the stored words and the factor.
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        check(64'({n_int, converter_power}), 64'h0);
        check(64'({band_settle_timeout, lock_settle_count}), 64'h0);
        // The fresh sync may report one early reference edge, so let it pass.
        repeat (16) @(posedge mclk);
        period(1'b0, per);
        check(64'(per), 64'd8);
        tally_and_finish();
    end

    // Watchdog well beyond the roughly sixteen thousand cycles the tests need.
    initial
    begin
        repeat (40000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
endmodule : sfc_top_tb_top
